// file: logic/ocd_decoder.sv
`timescale 1ns/100ps
// Operation
// - 0x15 plus two parameter bytes sets the column window.
// - first column parameter low six bits is column start, reset 0.
// - second column parameter low six bits is column end, reset 63.
// - column window command loads column pointer with column start.
// - 0x75 plus two parameter bytes sets the row window.
// - first row parameter low seven bits is row start 0 to 127, reset 0.
// - second row parameter is row end, reset 79.
// - row window command loads row pointer with row start.
// - 0x81 plus one parameter loads seven-bit contrast, reset 0x40.
// - 0x84, 0x85, 0x86 select quarter, half, full current range.
// - 0xA0 plus one parameter sets the re-map options.
// - column re-map reverses columns onto column driver outputs 127 to 0.
// - nibble re-map swaps upper and lower halves of RAM data bytes.
// - increment bit clear steps column pointer, set steps row pointer.
// - row re-map reverses rows onto row drivers 79 to 0.
// - split bit enables odd/even row driver split, reset clear.
// - 0xA1 plus one parameter loads display start line, reset 0.
// - data/command select marks command bytes versus display RAM data.
// - bytes arrive MSB first, sampled on falling serial clock edge.
// - each display data byte advances the RAM pointer inside the window.
module ocd_decoder (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic data_cmd_sel,
   input wire logic chip_sel_n,
   output logic [5:0] col_start,
   output logic [5:0] col_end,
   output logic [6:0] row_start,
   output logic [6:0] row_end,
   output logic [5:0] col_ptr,
   output logic [6:0] row_ptr,
   output logic [6:0] contrast,
   output ocd_pkg::ocd_range_t current_range,
   output ocd_pkg::ocd_remap_t remap,
   output logic [6:0] start_line,
   output logic ram_wr_en,
   output ocd_pkg::ocd_ram_wr_t ram_wr
);
   import ocd_pkg::*;

   typedef enum logic [2:0] {
      ocd_idle_e,
      ocd_col_a_e,
      ocd_col_b_e,
      ocd_row_a_e,
      ocd_row_b_e,
      ocd_contrast_e,
      ocd_remap_e,
      ocd_line_e
   } ocd_state_t;

   logic [2:0] sclk_sync_ff;
   logic [1:0] sdi_sync_ff;
   logic [1:0] dc_sync_ff;
   logic [1:0] cs_sync_ff;
   logic [2:0] bit_cnt_ff;
   logic [6:0] shift_ff;
   logic byte_vld_ff;
   logic [7:0] byte_ff;
   logic byte_dc_ff;
   ocd_state_t state_ff;
   ocd_state_t nxt_state;
   logic [5:0] col_a_ff;
   logic [6:0] row_a_ff;
   logic [5:0] col_start_ff;
   logic [5:0] col_end_ff;
   logic [6:0] row_start_ff;
   logic [6:0] row_end_ff;
   logic [5:0] col_ptr_ff;
   logic [6:0] row_ptr_ff;
   logic [6:0] contrast_ff;
   ocd_range_t range_ff;
   ocd_remap_t remap_ff;
   logic [6:0] start_line_ff;
   logic ram_wr_en_ff;
   ocd_ram_wr_t ram_wr_ff;
   logic sclk_fall;
   logic cmd_byte;
   logic data_byte;
   logic col_done;
   logic row_done;

   // synchronisers; first stage read only by second
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_sync_ff <= 3'h7;
         sdi_sync_ff <= 2'h0;
         dc_sync_ff <= 2'h0;
         cs_sync_ff <= 2'h3;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk};
         sdi_sync_ff <= {sdi_sync_ff[0], serial_data_in};
         dc_sync_ff <= {dc_sync_ff[0], data_cmd_sel};
         cs_sync_ff <= {cs_sync_ff[0], chip_sel_n};
      end
   end

   assign sclk_fall = sclk_sync_ff[2] & ~sclk_sync_ff[1];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_ff <= 3'h0;
         shift_ff <= 7'h00;
         byte_vld_ff <= 1'b0;
         byte_ff <= 8'h00;
         byte_dc_ff <= 1'b0;
      end else begin
         byte_vld_ff <= 1'b0;
         if (cs_sync_ff[1]) begin
            bit_cnt_ff <= 3'h0;
         end else if (sclk_fall) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff <= {shift_ff[5:0], sdi_sync_ff[1]};
            if (bit_cnt_ff == BIT_CNT_LAST) begin
               byte_vld_ff <= 1'b1;
               byte_ff <= {shift_ff, sdi_sync_ff[1]};
               byte_dc_ff <= dc_sync_ff[1];
            end
         end
      end
   end

   assign cmd_byte = byte_vld_ff & ~byte_dc_ff;
   assign data_byte = byte_vld_ff & byte_dc_ff;

   always_comb begin
      nxt_state = state_ff;
      if (cmd_byte) begin
         unique case (state_ff)
            ocd_idle_e: begin
               case (byte_ff)
                  CMD_COL_WIN: nxt_state = ocd_col_a_e;
                  CMD_ROW_WIN: nxt_state = ocd_row_a_e;
                  CMD_CONTRAST: nxt_state = ocd_contrast_e;
                  CMD_REMAP: nxt_state = ocd_remap_e;
                  CMD_START_LINE: nxt_state = ocd_line_e;
                  default: nxt_state = ocd_idle_e;
               endcase
            end
            ocd_col_a_e: nxt_state = ocd_col_b_e;
            ocd_row_a_e: nxt_state = ocd_row_b_e;
            ocd_col_b_e, ocd_row_b_e, ocd_contrast_e, ocd_remap_e, ocd_line_e: nxt_state = ocd_idle_e;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ocd_idle_e;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         col_a_ff <= COL_START_RST;
         row_a_ff <= ROW_START_RST;
         col_start_ff <= COL_START_RST;
         col_end_ff <= COL_END_RST;
         row_start_ff <= ROW_START_RST;
         row_end_ff <= ROW_END_RST;
         contrast_ff <= CONTRAST_RST;
         range_ff <= ocd_range_qtr_e;
         remap_ff <= '0;
         start_line_ff <= START_LINE_RST;
      end else if (cmd_byte) begin
         unique case (state_ff)
            ocd_idle_e: begin
               if (byte_ff == CMD_RANGE_QTR) range_ff <= ocd_range_qtr_e;
               if (byte_ff == CMD_RANGE_HALF) range_ff <= ocd_range_half_e;
               if (byte_ff == CMD_RANGE_FULL) range_ff <= ocd_range_full_e;
            end
            ocd_col_a_e: col_a_ff <= byte_ff[5:0];
            ocd_col_b_e: begin
               col_start_ff <= col_a_ff;
               col_end_ff <= byte_ff[5:0];
            end
            ocd_row_a_e: row_a_ff <= byte_ff[6:0];
            ocd_row_b_e: begin
               row_start_ff <= row_a_ff;
               row_end_ff <= byte_ff[6:0];
            end
            ocd_contrast_e: contrast_ff <= byte_ff[6:0];
            ocd_remap_e: begin
               remap_ff.col_rev <= byte_ff[REMAP_COL_BIT];
               remap_ff.nibble_swap <= byte_ff[REMAP_NIB_BIT];
               remap_ff.vert_inc <= byte_ff[REMAP_INC_BIT];
               remap_ff.row_rev <= byte_ff[REMAP_ROW_BIT];
               remap_ff.split <= byte_ff[REMAP_SPLIT_BIT];
            end
            ocd_line_e: start_line_ff <= byte_ff[6:0];
         endcase
      end
   end

   assign col_done = (col_ptr_ff == col_end_ff);
   assign row_done = (row_ptr_ff == row_end_ff);

   // address pointers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         col_ptr_ff <= COL_START_RST;
         row_ptr_ff <= ROW_START_RST;
      end else if (cmd_byte && state_ff == ocd_col_b_e) begin
         col_ptr_ff <= col_a_ff;
      end else if (cmd_byte && state_ff == ocd_row_b_e) begin
         row_ptr_ff <= row_a_ff;
      end else if (data_byte) begin
         if (!remap_ff.vert_inc) begin
            col_ptr_ff <= col_done ? col_start_ff : col_ptr_ff + 6'h01;
            if (col_done) row_ptr_ff <= row_done ? row_start_ff : row_ptr_ff + 7'h01;
         end else begin
            row_ptr_ff <= row_done ? row_start_ff : row_ptr_ff + 7'h01;
            if (row_done) col_ptr_ff <= col_done ? col_start_ff : col_ptr_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ram_wr_en_ff <= 1'b0;
         ram_wr_ff <= '0;
      end else begin
         ram_wr_en_ff <= data_byte;
         if (data_byte) begin
            ram_wr_ff.col <= col_ptr_ff;
            ram_wr_ff.row <= row_ptr_ff;
            ram_wr_ff.data <= remap_ff.nibble_swap ? {byte_ff[3:0], byte_ff[7:4]} : byte_ff;
         end
      end
   end

   // reversal applied by the scan drivers from remap
   assign col_start = col_start_ff;
   assign col_end = col_end_ff;
   assign row_start = row_start_ff;
   assign row_end = row_end_ff;
   assign col_ptr = col_ptr_ff;
   assign row_ptr = row_ptr_ff;
   assign contrast = contrast_ff;
   assign current_range = range_ff;
   assign remap = remap_ff;
   assign start_line = start_line_ff;
   assign ram_wr_en = ram_wr_en_ff;
   assign ram_wr = ram_wr_ff;

   sequence s_col_param_b;
      cmd_byte && state_ff == ocd_col_b_e;
   endsequence

   sequence s_row_param_b;
      cmd_byte && state_ff == ocd_row_b_e;
   endsequence

   a_col_ptr_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_col_param_b |=> col_ptr_ff == $past(col_a_ff) && col_start_ff == col_ptr_ff)
      else $error("column pointer not loaded");
   a_col_end_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_col_param_b |=> col_end_ff == $past(byte_ff[5:0]))
      else $error("column end not loaded");
   a_row_ptr_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_row_param_b |=> row_ptr_ff == $past(row_a_ff) && row_start_ff == row_ptr_ff)
      else $error("row pointer not loaded");
   a_row_end_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_row_param_b |=> row_end_ff == $past(byte_ff[6:0]))
      else $error("row end not loaded");
   a_contrast_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_contrast_e |=> contrast_ff == $past(byte_ff[6:0]))
      else $error("contrast not loaded");
   a_range_full: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_idle_e && byte_ff == CMD_RANGE_FULL |=> range_ff == ocd_range_full_e)
      else $error("full range not selected");
   a_three_byte_cmd: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_idle_e && byte_ff == CMD_COL_WIN |=> state_ff == ocd_col_a_e)
      else $error("column command not parsed");
   a_line_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_line_e |=> start_line_ff == $past(byte_ff[6:0]) && state_ff == ocd_idle_e)
      else $error("start line not loaded");
   a_nibble_swap: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte && remap_ff.nibble_swap |=> ram_wr_en_ff && ram_wr_ff.data[3:0] == $past(byte_ff[7:4]))
      else $error("nibbles not swapped");
   a_col_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte && !remap_ff.vert_inc && col_done |=> col_ptr_ff == col_start_ff)
      else $error("column pointer did not wrap");
   a_horiz_step: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte && !remap_ff.vert_inc && !col_done |=> col_ptr_ff == $past(col_ptr_ff) + 6'h01)
      else $error("column pointer did not step");
   a_dc_data: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte |=> !ram_wr_en_ff)
      else $error("command byte written to ram");

   sequence s_last_bit;
      !cs_sync_ff[1] && sclk_fall && bit_cnt_ff == BIT_CNT_LAST;
   endsequence

   sequence s_remap_param;
      cmd_byte && state_ff == ocd_remap_e;
   endsequence

   a_byte_msb_first: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_last_bit |=> byte_vld_ff && byte_ff == {$past(shift_ff), $past(sdi_sync_ff[1])})
      else $error("serial byte not assembled msb first");
   a_col_param_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_col_a_e |=> col_a_ff == $past(byte_ff[5:0]) && state_ff == ocd_col_b_e)
      else $error("column start parameter not taken");
   a_row_cmd_parse: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_idle_e && byte_ff == CMD_ROW_WIN |=> state_ff == ocd_row_a_e)
      else $error("row command not parsed");
   a_row_param_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_row_a_e |=> row_a_ff == $past(byte_ff[6:0]) && state_ff == ocd_row_b_e)
      else $error("row start parameter not taken");
   a_range_half: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmd_byte && state_ff == ocd_idle_e && byte_ff == CMD_RANGE_HALF |=> range_ff == ocd_range_half_e)
      else $error("half range not selected");
   a_col_remap: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_remap_param |=> remap_ff.col_rev == $past(byte_ff[REMAP_COL_BIT]))
      else $error("column re-map bit not loaded");
   a_row_remap: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_remap_param |=> remap_ff.row_rev == $past(byte_ff[REMAP_ROW_BIT]))
      else $error("row re-map bit not loaded");
   a_split_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_remap_param |=> remap_ff.split == $past(byte_ff[REMAP_SPLIT_BIT]))
      else $error("split bit not loaded");
   a_vert_step: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte && remap_ff.vert_inc && !row_done |=> row_ptr_ff == $past(row_ptr_ff) + 7'h01 && $stable(col_ptr_ff))
      else $error("row pointer did not step");
   a_ram_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte |=> ram_wr_en_ff && ram_wr_ff.col == $past(col_ptr_ff) && ram_wr_ff.row == $past(row_ptr_ff))
      else $error("ram write address wrong");
   a_row_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_byte && remap_ff.vert_inc && row_done |=> row_ptr_ff == row_start_ff)
      else $error("row pointer did not wrap");
endmodule

// file: logic/ocd_pkg.sv
package ocd_pkg;
   localparam logic [7:0] CMD_COL_WIN = 8'h15;
   localparam logic [7:0] CMD_ROW_WIN = 8'h75;
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [7:0] CMD_RANGE_QTR = 8'h84;
   localparam logic [7:0] CMD_RANGE_HALF = 8'h85;
   localparam logic [7:0] CMD_RANGE_FULL = 8'h86;
   localparam logic [7:0] CMD_REMAP = 8'ha0;
   localparam logic [7:0] CMD_START_LINE = 8'ha1;
   localparam logic [5:0] COL_START_RST = 6'h00;
   localparam logic [5:0] COL_END_RST = 6'h3f;
   localparam logic [6:0] ROW_START_RST = 7'h00;
   localparam logic [6:0] ROW_END_RST = 7'h4f;
   localparam logic [6:0] ROW_MAX = 7'h4f;
   localparam logic [6:0] CONTRAST_RST = 7'h40;
   localparam logic [6:0] START_LINE_RST = 7'h00;
   localparam int REMAP_COL_BIT = 0;
   localparam int REMAP_NIB_BIT = 1;
   localparam int REMAP_INC_BIT = 2;
   localparam int REMAP_ROW_BIT = 4;
   localparam int REMAP_SPLIT_BIT = 6;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;

   typedef enum logic [1:0] {
      ocd_range_qtr_e,
      ocd_range_half_e,
      ocd_range_full_e
   } ocd_range_t;

   typedef struct packed {
      logic col_rev;
      logic nibble_swap;
      logic vert_inc;
      logic row_rev;
      logic split;
   } ocd_remap_t;

   typedef struct packed {
      logic [5:0] col;
      logic [6:0] row;
      logic [7:0] data;
   } ocd_ram_wr_t;
endpackage

// file: sim/ocd_decoder_test.sv
`timescale 1ns/100ps
module ocd_decoder_test;
   import ocd_pkg::*;
   logic ref_clk, rstn, serial_clk, serial_data_in, data_cmd_sel, chip_sel_n;
   logic [5:0] col_start, col_end, col_ptr;
   logic [6:0] row_start, row_end, row_ptr, contrast, start_line;
   ocd_range_t current_range;
   ocd_remap_t remap;
   logic ram_wr_en;
   ocd_ram_wr_t ram_wr;
   ocd_ram_wr_t wr_q[$];
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;

   ocd_decoder i_ocd_decoder (.ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .data_cmd_sel(data_cmd_sel), .chip_sel_n(chip_sel_n),
      .col_start(col_start), .col_end(col_end), .row_start(row_start), .row_end(row_end),
      .col_ptr(col_ptr), .row_ptr(row_ptr), .contrast(contrast), .current_range(current_range),
      .remap(remap), .start_line(start_line), .ram_wr_en(ram_wr_en), .ram_wr(ram_wr));

   ocd_host_model i_ocd_host_model (.ref_clk(ref_clk), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .data_cmd_sel(data_cmd_sel), .chip_sel_n(chip_sel_n));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (ram_wr_en === 1'b1) begin
         wr_q.push_back(ram_wr);
      end
   end

   task automatic final_report();
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // command frame of n bytes, then settle
   task automatic cmds(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
      i_ocd_host_model.send(1'b0, b0);
      if (n > 1) i_ocd_host_model.send(1'b0, b1);
      if (n > 2) i_ocd_host_model.send(1'b0, b2);
      i_ocd_host_model.stop();
   endtask

   task automatic dat(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         i_ocd_host_model.send(1'b1, base + 8'(i));
      end
      i_ocd_host_model.stop();
   endtask

   // pops one captured write and compares col, row, data
   task automatic chk_wr(input logic [5:0] c, input logic [6:0] r, input logic [7:0] d);
      ocd_ram_wr_t w;
      w = '0;
      if (wr_q.size() > 0) begin
         w = wr_q.pop_front();
      end
      chk(32'(w), 32'({c, r, d}));
   endtask

   initial begin
      rstn = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(32'({col_start, col_end}), 32'({6'h00, 6'h3f}));
      chk(32'({row_start, row_end}), 32'({7'h00, 7'h4f}));
      chk(32'(contrast), 32'h40);
      chk(32'(current_range), 32'(ocd_range_qtr_e));
      chk(32'(remap), 32'h0);
      chk(32'(start_line), 32'h0);
      chk(32'({col_ptr, row_ptr, ram_wr_en}), 32'h0);
      cmds(8'h15, 8'hc5, 8'h86, 3);
      chk(32'({col_start, col_end, col_ptr}), 32'({6'h05, 6'h06, 6'h05}));
      cmds(8'h75, 8'h02, 8'h03, 3);
      chk(32'({row_start, row_end, row_ptr}), 32'({7'h02, 7'h03, 7'h02}));
      cmds(8'h81, 8'hff, 8'h00, 2);
      chk(32'(contrast), 32'h7f);
      for (int k = 0; k < 3; k++) begin
         cmds(8'h85 + 8'(k % 2), 8'h00, 8'h00, 1);
         chk(32'(current_range), 32'(k % 2 == 0 ? ocd_range_half_e : ocd_range_full_e));
      end
      cmds(8'h84, 8'h00, 8'h00, 1);
      chk(32'(current_range), 32'(ocd_range_qtr_e));
      cmds(8'ha0, 8'h57, 8'h00, 2);
      chk(32'(remap), 32'h1f);
      cmds(8'ha1, 8'h4f, 8'h00, 2);
      chk(32'(start_line), 32'h4f);
      cmds(8'ha0, 8'h00, 8'h00, 2);
      chk(32'(remap), 32'h0);
      wr_q.delete();
      dat(5, 8'h3c);
      chk(32'(wr_q.size()), 32'd5);
      chk_wr(6'h05, 7'h02, 8'h3c);
      chk_wr(6'h06, 7'h02, 8'h3d);
      chk_wr(6'h05, 7'h03, 8'h3e);
      chk_wr(6'h06, 7'h03, 8'h3f);
      chk_wr(6'h05, 7'h02, 8'h40);
      chk(32'(contrast), 32'h7f);
      cmds(8'ha0, 8'h15, 8'h00, 2);
      chk(32'(remap), 32'h16);
      cmds(8'h15, 8'h05, 8'h06, 3);
      cmds(8'h75, 8'h02, 8'h03, 3);
      dat(3, 8'ha5);
      chk_wr(6'h05, 7'h02, 8'ha5);
      chk_wr(6'h05, 7'h03, 8'ha6);
      chk_wr(6'h06, 7'h02, 8'ha7);
      cmds(8'ha0, 8'h42, 8'h00, 2);
      chk(32'(remap), 32'h09);
      dat(1, 8'h3c);
      chk_wr(6'h06, 7'h03, 8'hc3);
      chk(32'({col_ptr, row_ptr}), 32'({6'h05, 7'h02}));
      cmds(8'h86, 8'h00, 8'h00, 1);
      cmds(8'h81, 8'h12, 8'h00, 2);
      chk(32'({contrast, current_range}), 32'({7'h12, ocd_range_full_e}));
      rstn = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(32'({col_start, col_end, col_ptr}), 32'({6'h00, 6'h3f, 6'h00}));
      chk(32'({row_start, row_end, row_ptr}), 32'({7'h00, 7'h4f, 7'h00}));
      chk(32'({contrast, current_range}), 32'({7'h40, ocd_range_qtr_e}));
      chk(32'({remap, start_line}), 32'h0);
      cmds(8'ha1, 8'h25, 8'h00, 2);
      chk(32'(start_line), 32'h25);
      final_report();
   end
endmodule

// file: sim/ocd_host_model.sv
`timescale 1ns/100ps
module ocd_host_model (
   input wire logic ref_clk,
   output logic serial_clk,
   output logic serial_data_in,
   output logic data_cmd_sel,
   output logic chip_sel_n
);
   initial begin
      serial_clk = 1'b1;
      serial_data_in = 1'b0;
      data_cmd_sel = 1'b0;
      chip_sel_n = 1'b1;
   end

   // half serial period of 80 ns, moves just after a system edge
   task automatic half();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask

   task automatic send(input logic dc, input logic [7:0] b);
      chip_sel_n = 1'b0;
      data_cmd_sel = dc;
      for (int i = 7; i >= 0; i--) begin
         serial_data_in = b[i];
         half();
         serial_clk = 1'b0;
         half();
         serial_clk = 1'b1;
      end
   endtask

   // deselect; data line no longer carries the last bit
   task automatic stop();
      half();
      chip_sel_n = 1'b1;
      serial_data_in = ~serial_data_in;
      half();
   endtask
endmodule
